// [hw/uiac_core.sv]
// Configuration, interface and alternate-setting bookkeeping of the USB function controller
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uiac_defs.svh"
module uiac_core
    import uiac_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    input  wire logic       soft_reset_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       bus_reset_in,
    input  wire logic       desc_hw_set_in,
    input  wire logic       max_packet_set_in,
    input  wire logic       req_valid_in,
    input  wire uiac_req_t  req_code_in,
    input  wire logic [7:0] req_value_in,
    input  wire logic [7:0] req_index_in,
    output logic            req_ack_out,
    output logic            req_stall_out,
    output logic            req_fw_out,
    output logic      [7:0] req_data_out,
    input  wire logic       tok_valid_in,
    input  wire logic [3:0] tok_ep_in,
    output logic            tok_accept_out,
    output logic            configured_out,
    output logic            ep_one_valid_out,
    output logic            ep_two_valid_out
);
    logic       clr;
    logic       configured_flag_reg;
    logic       default_response_flag_reg;
    logic       max_packet_flag_reg;
    logic       force_descriptor_to_firmware_reg;
    logic [7:0] active_interface_count_reg;
    logic [7:0] alt_setting_link_reg;
    logic [2:0] five_series_state_reg;
    logic       two_series_state_reg;
    logic [7:0] ep_one_interface_map_reg;
    logic [7:0] ep_two_interface_map_reg;
    logic [2:0] if_alt_reg [0:`UIAC_NUM_IF-1];
    logic [2:0] max_if;
    logic       five_ok;
    logic       two_ok;
    logic [2:0] five_if;
    logic [2:0] two_if;
    logic [2:0] req_if;
    logic [2:0] req_alt;
    logic       if_ok;
    logic       set_if_ok;
    logic       ep1_valid;
    logic       ep2_valid;
    logic       ep_req_ok;
    logic       cfg_req;
    logic       set_if_go;
    logic [7:0] rdata_next;

    // Controller soft reset returns everything except reg_rdata_out to its power-up state
    assign clr = !reset_n_in || soft_reset_in;

    // Valid interface ceiling
    always_comb
    begin
        if (active_interface_count_reg[`UIAC_EXTRA_INTERFACES_ENABLE_BIT])
            max_if = {1'b0, active_interface_count_reg[1:0]} + 3'h1;
        else
            max_if = 3'h0;
    end

    // Series links: link-to-zero overrides the interface field
    assign five_if = alt_setting_link_reg[`UIAC_FIVE_IF0_BIT] ? 3'h0
                   : {1'b0, alt_setting_link_reg[2:1]} + 3'h1;
    assign two_if  = alt_setting_link_reg[`UIAC_TWO_IF0_BIT] ? 3'h0
                   : {1'b0, alt_setting_link_reg[6:5]} + 3'h1;
    // Out-of-range link behaves as a disabled series
    assign five_ok = alt_setting_link_reg[`UIAC_FIVE_EN_BIT] && (five_if <= max_if);
    assign two_ok  = alt_setting_link_reg[`UIAC_TWO_EN_BIT] && (two_if <= max_if);

    // Upper index bits must be zero, so a large wIndex never aliases a real interface
    assign req_if  = req_index_in[2:0];
    assign if_ok   = (req_index_in[7:3] == 5'h00) && (req_if <= max_if);
    assign req_alt = req_value_in[2:0];

    // Allowed alternate for the addressed interface
    always_comb
    begin
        if (!if_ok || (req_value_in[7:3] != 5'h00))
            set_if_ok = 1'b0;
        else if (five_ok && (five_if == req_if))
            set_if_ok = (req_alt <= `UIAC_FIVE_LAST_ALT);
        else if (two_ok && (two_if == req_if))
            set_if_ok = (req_alt <= 3'h1);
        else
            set_if_ok = (req_alt == 3'h0);
    end

    uiac_ep_valid u_ep_one
    (
        .map_in        (ep_one_interface_map_reg),
        .configured_in (configured_flag_reg),
        .max_if_in     (max_if),
        .five_ok_in    (five_ok),
        .five_if_in    (five_if),
        .five_st_in    (five_series_state_reg),
        .two_ok_in     (two_ok),
        .two_if_in     (two_if),
        .two_st_in     (two_series_state_reg),
        .valid_out     (ep1_valid)
    );

    uiac_ep_valid u_ep_two
    (
        .map_in        (ep_two_interface_map_reg),
        .configured_in (configured_flag_reg),
        .max_if_in     (max_if),
        .five_ok_in    (five_ok),
        .five_if_in    (five_if),
        .five_st_in    (five_series_state_reg),
        .two_ok_in     (two_ok),
        .two_if_in     (two_if),
        .two_st_in     (two_series_state_reg),
        .valid_out     (ep2_valid)
    );

    assign ep_one_valid_out = ep1_valid;
    assign ep_two_valid_out = ep2_valid;
    assign configured_out   = configured_flag_reg;

    // Feature/status request target: endpoint in wIndex low nibble
    always_comb
    begin
        ep_req_ok = 1'b0;
        if (req_index_in[3:0] == `UIAC_EP_ZERO)
            ep_req_ok = 1'b1;
        else if (req_index_in[3:0] == `UIAC_EP_ONE)
            ep_req_ok = ep1_valid;
        else if (req_index_in[3:0] == `UIAC_EP_TWO)
            ep_req_ok = ep2_valid;
    end

    // Token acceptance is combinational so the packet engine can answer in time
    always_comb
    begin
        tok_accept_out = 1'b0;
        if (tok_valid_in && default_response_flag_reg)
        begin
            if (tok_ep_in == `UIAC_EP_ZERO)
                tok_accept_out = 1'b1;
            else if (configured_flag_reg)
                tok_accept_out = ((tok_ep_in == `UIAC_EP_ONE) && ep1_valid)
                              || ((tok_ep_in == `UIAC_EP_TWO) && ep2_valid);
        end
    end

    assign cfg_req   = req_valid_in && (req_code_in == UIAC_REQ_SET_CONFIG);
    assign set_if_go = req_valid_in && (req_code_in == UIAC_REQ_SET_IF) && set_if_ok;

    // Configured flag; a SET_CONFIGURATION of 0 or 1 in the bus-reset cycle wins
    always_ff @(posedge mclk_in)
    begin
        if (clr)
            configured_flag_reg <= 1'b0;
        else if (cfg_req && (req_value_in == `UIAC_CFG_ON))
            configured_flag_reg <= 1'b1;
        else if (cfg_req && (req_value_in == `UIAC_CFG_OFF))
            configured_flag_reg <= 1'b0;
        else if (bus_reset_in)
            configured_flag_reg <= 1'b0;
    end

    always_ff @(posedge mclk_in)
    begin
        if (clr)
            default_response_flag_reg <= 1'b0;
        else if (bus_reset_in)
            default_response_flag_reg <= 1'b1;
    end

    // Survives bus reset by design
    always_ff @(posedge mclk_in)
    begin
        if (clr)
            max_packet_flag_reg <= 1'b0;
        else if (max_packet_set_in)
            max_packet_flag_reg <= 1'b1;
    end

    // Descriptor routing bit: firmware write beats the hardware set
    always_ff @(posedge mclk_in)
    begin
        if (clr)
            force_descriptor_to_firmware_reg <= 1'b0;
        else if (reg_wr_in && (reg_addr_in == `UIAC_OFF_DESC_CTRL))
            force_descriptor_to_firmware_reg <= reg_wdata_in[`UIAC_DESC_BIT];
        else if (desc_hw_set_in)
            force_descriptor_to_firmware_reg <= 1'b1;
    end

    // Firmware configuration registers
    always_ff @(posedge mclk_in)
    begin
        if (clr)
        begin
            active_interface_count_reg <= `UIAC_RST_8;
            alt_setting_link_reg       <= `UIAC_RST_8;
            ep_one_interface_map_reg   <= `UIAC_RST_8;
            ep_two_interface_map_reg   <= `UIAC_RST_8;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == `UIAC_OFF_IF_COUNT)
                active_interface_count_reg <= reg_wdata_in & `UIAC_IF_COUNT_MASK;
            if (reg_addr_in == `UIAC_OFF_ALT_LINK)
                alt_setting_link_reg <= reg_wdata_in;
            if (reg_addr_in == `UIAC_OFF_EP1_MAP)
                ep_one_interface_map_reg <= reg_wdata_in;
            if (reg_addr_in == `UIAC_OFF_EP2_MAP)
                ep_two_interface_map_reg <= reg_wdata_in;
        end
    end

    // Selected alternates; bus reset returns every interface to setting 0
    always_ff @(posedge mclk_in)
    begin
        if (clr || bus_reset_in)
        begin
            five_series_state_reg <= 3'h0;
            two_series_state_reg  <= 1'b0;
            for (int i = 0; i < `UIAC_NUM_IF; i++)
                if_alt_reg[i] <= 3'h0;
        end
        else if (set_if_go)
        begin
            if_alt_reg[req_if] <= req_alt;
            if (five_ok && (five_if == req_if))
                five_series_state_reg <= req_alt;
            else if (two_ok && (two_if == req_if))
                two_series_state_reg <= req_alt[0];
        end
    end

    // Request answers, one-cycle pulses after the request
    always_ff @(posedge mclk_in)
    begin
        if (clr)
        begin
            req_ack_out   <= 1'b0;
            req_stall_out <= 1'b0;
            req_fw_out    <= 1'b0;
            req_data_out  <= 8'h00;
        end
        else
        begin
            req_ack_out   <= 1'b0;
            req_stall_out <= 1'b0;
            req_fw_out    <= 1'b0;
            req_data_out  <= 8'h00;
            if (req_valid_in)
            begin
                unique case (req_code_in)
                    UIAC_REQ_SET_CONFIG:
                    begin
                        req_ack_out   <= (req_value_in <= `UIAC_CFG_ON);
                        req_stall_out <= (req_value_in > `UIAC_CFG_ON);
                    end
                    UIAC_REQ_GET_IF:
                    begin
                        req_ack_out   <= if_ok;
                        req_stall_out <= !if_ok;
                        if (if_ok)
                            req_data_out <= {5'h00, if_alt_reg[req_if]};
                    end
                    UIAC_REQ_SET_IF:
                    begin
                        req_ack_out   <= set_if_ok;
                        req_stall_out <= !set_if_ok;
                    end
                    UIAC_REQ_GET_DESC_CFG:
                    begin
                        req_fw_out  <= force_descriptor_to_firmware_reg;
                        req_ack_out <= !force_descriptor_to_firmware_reg;
                    end
                    UIAC_REQ_EP_FEATURE:
                    begin
                        req_ack_out   <= ep_req_ok;
                        req_stall_out <= !ep_req_ok;
                    end
                    default:
                    begin
                        req_stall_out <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Register read path, data in the cycle after the strobe
    always_comb
    begin
        rdata_next = 8'h00;
        unique case (reg_addr_in)
            `UIAC_OFF_DESC_CTRL: rdata_next = {1'b0, force_descriptor_to_firmware_reg, 6'h00};
            `UIAC_OFF_MODE_STAT: rdata_next = {1'b0, force_descriptor_to_firmware_reg, 1'b0,
                                               max_packet_flag_reg, default_response_flag_reg,
                                               configured_flag_reg, 2'h0};
            `UIAC_OFF_IF_COUNT:  rdata_next = active_interface_count_reg;
            `UIAC_OFF_ALT_LINK:  rdata_next = alt_setting_link_reg;
            `UIAC_OFF_ALT_STATE: rdata_next = {4'h0, five_series_state_reg, two_series_state_reg};
            `UIAC_OFF_EP1_MAP:   rdata_next = ep_one_interface_map_reg;
            `UIAC_OFF_EP2_MAP:   rdata_next = ep_two_interface_map_reg;
            default:
            begin
                for (int i = 0; i < `UIAC_NUM_IF; i++)
                    if (reg_addr_in == `UIAC_OFF_IF_ALT0 + 16'(i) * `UIAC_IF_ALT_STEP)
                        rdata_next = {5'h00, if_alt_reg[i]};
            end
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in)
            reg_rdata_out <= rdata_next;
        else
            reg_rdata_out <= 8'h00;
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in || soft_reset_in);

    property p_configured_flag_set;
        cfg_req && (req_value_in == 8'h01) |=> configured_flag_reg;
    endproperty
    a_configured_flag_set: assert property (p_configured_flag_set) else $error("configured flag not set");

    property p_tok_ignored;
        tok_valid_in && (tok_ep_in != 4'h0) && !configured_flag_reg |-> !tok_accept_out;
    endproperty
    a_tok_ignored: assert property (p_tok_ignored) else $error("endpoint answered while unconfigured");

    property p_configured_flag_clr;
        cfg_req && (req_value_in == 8'h00) |=> !configured_flag_reg && req_ack_out;
    endproperty
    a_configured_flag_clr: assert property (p_configured_flag_clr) else $error("configured flag not cleared");

    property p_bus_reset;
        bus_reset_in && !cfg_req |=> !configured_flag_reg && default_response_flag_reg;
    endproperty
    a_bus_reset: assert property (p_bus_reset) else $error("bus reset effect missing");

    property p_no_default_response_flag;
        !default_response_flag_reg |-> !tok_accept_out;
    endproperty
    a_no_default_response_flag: assert property (p_no_default_response_flag) else $error("answer without default response");

    property p_getif_range;
        req_valid_in && (req_code_in == UIAC_REQ_GET_IF) && (req_index_in > 8'(max_if))
            |=> req_stall_out && !req_ack_out;
    endproperty
    a_getif_range: assert property (p_getif_range) else $error("bad GET_INTERFACE not stalled");

    property p_setif_zero;
        req_valid_in && (req_code_in == UIAC_REQ_SET_IF) && (req_index_in == 8'h00)
            && (req_value_in == 8'h00) && !bus_reset_in |=> req_ack_out && (if_alt_reg[0] == 3'h0);
    endproperty
    a_setif_zero: assert property (p_setif_zero) else $error("interface 0 setting 0 refused");

    property p_ep_unconf;
        !configured_flag_reg |-> !ep1_valid && !ep2_valid;
    endproperty
    a_ep_unconf: assert property (p_ep_unconf) else $error("endpoint valid while unconfigured");

    property p_desc_route;
        req_valid_in && (req_code_in == UIAC_REQ_GET_DESC_CFG) && force_descriptor_to_firmware_reg
            |=> req_fw_out && !req_ack_out;
    endproperty
    a_desc_route: assert property (p_desc_route) else $error("descriptor not routed");

    property p_fw_wins;
        reg_wr_in && (reg_addr_in == 16'h40e8) && desc_hw_set_in
            |=> force_descriptor_to_firmware_reg == $past(reg_wdata_in[6]);
    endproperty
    a_fw_wins: assert property (p_fw_wins) else $error("hardware set beat firmware write");
endmodule
`default_nettype wire

// [hw/uiac_defs.svh]
// Offsets, field positions, reset values and limits of the interface bookkeeping block
`ifndef UIAC_DEFS_SVH
`define UIAC_DEFS_SVH
`define UIAC_ADDR_W          16
`define UIAC_OFF_DESC_CTRL   16'h40e8
`define UIAC_OFF_MODE_STAT   16'h40f0
`define UIAC_OFF_IF_COUNT    16'h4100
`define UIAC_OFF_ALT_LINK    16'h4104
`define UIAC_OFF_ALT_STATE   16'h4108
`define UIAC_OFF_EP1_MAP     16'h410c
`define UIAC_OFF_EP2_MAP     16'h4110
`define UIAC_OFF_IF_ALT0     16'h4140
`define UIAC_IF_ALT_STEP     16'h0004
`define UIAC_RST_8           8'h00
`define UIAC_DESC_BIT        6
`define UIAC_MAX_PACKET_FLAG_BIT       4
`define UIAC_DEFAULT_RESPONSE_FLAG_BIT        3
`define UIAC_CONFIGURED_FLAG_BIT        2
`define UIAC_EXTRA_INTERFACES_ENABLE_BIT       7
`define UIAC_FIVE_IF0_BIT    3
`define UIAC_FIVE_EN_BIT     0
`define UIAC_TWO_IF0_BIT     7
`define UIAC_TWO_EN_BIT      4
`define UIAC_IF_COUNT_MASK   8'h83
`define UIAC_DESC_MASK       8'h40
`define UIAC_NUM_IF          5
`define UIAC_LAST_IF         3'h4
`define UIAC_FIVE_LAST_ALT   3'h4
`define UIAC_CFG_ON          8'h01
`define UIAC_CFG_OFF         8'h00
`define UIAC_EP_ZERO         4'h0
`define UIAC_EP_ONE          4'h1
`define UIAC_EP_TWO          4'h2
`endif

// [hw/uiac_ep_valid.sv]
// Validity of one data endpoint from its map register and the selected alternate settings
`timescale 1ns/1ps
`default_nettype none
module uiac_ep_valid
(
    input  wire logic [7:0] map_in,
    input  wire logic       configured_in,
    input  wire logic [2:0] max_if_in,
    input  wire logic       five_ok_in,
    input  wire logic [2:0] five_if_in,
    input  wire logic [2:0] five_st_in,
    input  wire logic       two_ok_in,
    input  wire logic [2:0] two_if_in,
    input  wire logic       two_st_in,
    output logic            valid_out
);
    logic [2:0] link;
    logic [2:0] ifn;
    logic       linked;
    logic       alt_ok;

    assign link = map_in[7:5];
    // 110 and 111 never link, whatever the alternate-enable bits hold
    assign linked = (link != 3'h0) && (link <= 3'h5);
    assign ifn = link - 3'h1;

    always_comb
    begin
        alt_ok = 1'b1;
        if (five_ok_in && (five_if_in == ifn))
        begin
            // Setting 0 is always allowed, settings 1-4 need their enable bit
            if (five_st_in != 3'h0)
                alt_ok = map_in[five_st_in[1:0] - 2'h1];
        end
        else if (two_ok_in && (two_if_in == ifn))
        begin
            if (two_st_in)
                alt_ok = map_in[4];
        end
    end

    // Only a configured device has live data endpoints
    assign valid_out = configured_in && linked && (ifn <= max_if_in) && alt_ok;
endmodule
`default_nettype wire

// [hw/uiac_pkg.sv]
// Types shared by the interface bookkeeping block
package uiac_pkg;
    typedef enum logic [2:0] {
        UIAC_REQ_SET_CONFIG,
        UIAC_REQ_GET_IF,
        UIAC_REQ_SET_IF,
        UIAC_REQ_GET_DESC_CFG,
        UIAC_REQ_EP_FEATURE
    } uiac_req_t;
endpackage

// [tb/uiac_host.sv]
// Host side model: decoded standard requests, endpoint tokens and bus resets
`timescale 1ns/1ps
`default_nettype none
module uiac_host
    import uiac_pkg::*;
(
    input  wire logic mclk_in,
    output uiac_req_t code_out,
    output logic      req_out,
    output logic [7:0] val_out,
    output logic [7:0] idx_out,
    output logic      tok_out,
    output logic [3:0] ep_out,
    output logic      brst_out
);
    initial {req_out, tok_out, brst_out, val_out, idx_out, ep_out} = '0;
    initial code_out = UIAC_REQ_SET_CONFIG;
    // Released value and index fields flip (the code is held) so a stale value is never mistaken for a request
    task automatic req(input uiac_req_t c, input logic [7:0] v, input logic [7:0] i);
        @(posedge mclk_in);
        req_out <= 1'b1;
        code_out <= c;
        val_out <= v;
        idx_out <= i;
        @(posedge mclk_in);
        req_out <= 1'b0;
        val_out <= ~v;
        idx_out <= ~i;
    endtask
    task automatic tok(input logic [3:0] e);
        @(posedge mclk_in);
        tok_out <= 1'b1;
        ep_out <= e;
        @(posedge mclk_in);
        tok_out <= 1'b0;
        ep_out <= ~e;
    endtask
    task automatic bus_reset();
        @(posedge mclk_in);
        brst_out <= 1'b1;
        @(posedge mclk_in);
        brst_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [tb/usb_interface_alt_config_bench.sv]
// Self-checking bench for the interface bookkeeping block
`timescale 1ns/1ps
`default_nettype none
`include "uiac_defs.svh"
module usb_interface_alt_config_bench
    import uiac_pkg::*;
();
    localparam logic [15:0] MS = `UIAC_OFF_MODE_STAT;
    localparam logic [15:0] DC = `UIAC_OFF_DESC_CTRL;
    localparam logic [15:0] IC = `UIAC_OFF_IF_COUNT;
    localparam logic [15:0] AL = `UIAC_OFF_ALT_LINK;
    localparam logic [15:0] ST = `UIAC_OFF_ALT_STATE;
    localparam logic [15:0] E1 = `UIAC_OFF_EP1_MAP;
    localparam logic [15:0] E2 = `UIAC_OFF_EP2_MAP;
    localparam logic [2:0] A = 3'h4;
    localparam logic [2:0] S = 3'h2;
    localparam logic [2:0] F = 3'h1;
    logic mclk_in = 1'b0, reset_n_in = 1'b0, soft_reset_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic desc_hw_set_in = 1'b0, max_packet_set_in = 1'b0, rd_d = 1'b0, req_d = 1'b0;
    logic [15:0] reg_addr_in = '0;
    logic [7:0] reg_wdata_in = '0, reg_rdata_out, req_value_in, req_index_in, req_data_out;
    logic req_ack_out, req_stall_out, req_fw_out, req_valid_in, tok_valid_in, bus_reset_in;
    logic tok_accept_out, configured_out, ep_one_valid_out, ep_two_valid_out;
    logic [3:0] tok_ep_in;
    uiac_req_t req_code_in;
    logic [10:0] aq[$];
    logic [7:0] rq_q[$], tq[$];
    logic [3:0] tok_view;
    int fails = 0;
    int tests_run = 0;
    uiac_core dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .soft_reset_in(soft_reset_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .bus_reset_in(bus_reset_in), .desc_hw_set_in(desc_hw_set_in),
        .max_packet_set_in(max_packet_set_in), .req_valid_in(req_valid_in), .req_code_in(req_code_in),
        .req_value_in(req_value_in), .req_index_in(req_index_in), .req_ack_out(req_ack_out),
        .req_stall_out(req_stall_out), .req_fw_out(req_fw_out), .req_data_out(req_data_out),
        .tok_valid_in(tok_valid_in), .tok_ep_in(tok_ep_in), .tok_accept_out(tok_accept_out),
        .configured_out(configured_out), .ep_one_valid_out(ep_one_valid_out), .ep_two_valid_out(ep_two_valid_out));
    assign tok_view = {configured_out, ep_one_valid_out, ep_two_valid_out, tok_accept_out};
    uiac_host h (.mclk_in(mclk_in), .code_out(req_code_in), .req_out(req_valid_in), .val_out(req_value_in),
        .idx_out(req_index_in), .tok_out(tok_valid_in), .ep_out(tok_ep_in), .brst_out(bus_reset_in));
    initial forever #50 mclk_in = ~mclk_in;
    task automatic cmp(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp({3'h0, got}, {3'h0, exp});
    endtask
    task automatic cmp_ans(input logic [10:0] got, input logic [10:0] exp);
        cmp(got, exp);
    endtask
    task automatic cmp_tok(input logic [3:0] got, input logic [3:0] exp);
        cmp({7'h0, got}, {7'h0, exp});
    endtask
    task automatic summarize();
        $display("counts: tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        rq_q.push_back(e);
        @(posedge mclk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
    endtask
    task automatic rq(input uiac_req_t c, input logic [7:0] v, i, input logic [2:0] r, input logic [7:0] d);
        aq.push_back({r, d});
        h.req(c, v, i);
    endtask
    // Token note: mask over {configured, ep1 valid, ep2 valid, accept}, then value
    task automatic tk(input logic [3:0] e, input logic [7:0] me);
        tq.push_back(me);
        h.tok(e);
    endtask
    always @(posedge mclk_in)
    begin
        rd_d <= reg_rd_in;
        req_d <= req_valid_in;
    end
    always @(negedge mclk_in)
    begin
        logic [7:0] t;
        if (rd_d)
            cmp_reg(reg_rdata_out, rq_q.pop_front());
        if (req_d || req_ack_out || req_stall_out || req_fw_out)
            cmp_ans({req_ack_out, req_stall_out, req_fw_out, req_data_out}, aq.pop_front());
        if (tok_valid_in)
        begin
            t = tq.pop_front();
            cmp_tok(t[7:4] & tok_view, t[3:0]);
        end
    end
    initial
    begin
        repeat (20000) @(posedge mclk_in);
        fails++;
        summarize();
    end
    initial
    begin
        logic [15:0] offs [8];
        logic [11:0] si [9];
        logic [11:0] et [6];
        logic [7:0] r;
        offs = '{DC, MS, IC, AL, ST, E1, E2, 16'h4000};
        si = '{12'h004, 12'h102, 12'h114, 12'h212, 12'h024, 12'h122, 12'h434, 12'h532, 12'h042};
        et = '{12'h800, 12'h881, 12'hc80, 12'he80, 12'h201, 12'ha00};
        r = 8'($urandom(32'h8135));
        repeat (8) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        foreach (offs[k])
            rd(offs[k], 8'h00);
        tk(4'h0, 8'h10);
        @(posedge mclk_in);
        max_packet_set_in <= 1'b1;
        @(posedge mclk_in);
        max_packet_set_in <= 1'b0;
        h.bus_reset();
        rd(MS, 8'h18);
        tk(4'h0, 8'h11);
        tk(4'h1, 8'h10);
        $display("test reset done");
        wr(IC, 8'hff);
        rd(IC, 8'h83);
        wr(IC, 8'h82);
        wr(AL, 8'h15); // Two series kept on distinct interfaces
        rd(AL, 8'h15);
        for (int k = 0; k < 5; k++)
            rq(UIAC_REQ_GET_IF, 8'h00, 8'(k), (k < 4) ? A : S, 8'h00);
        foreach (si[k])
            rq(UIAC_REQ_SET_IF, {4'h0, si[k][11:8]}, {4'h0, si[k][7:4]}, si[k][2:0], 8'h00);
        rd(ST, 8'h09);
        rd(`UIAC_OFF_IF_ALT0 + 16'h0004, 8'h01);
        rd(`UIAC_OFF_IF_ALT0 + 16'h000c, 8'h04);
        rq(UIAC_REQ_GET_IF, 8'h00, 8'h03, A, 8'h04);
        wr(ST, 8'hff);
        rd(ST, 8'h09);
        $display("test interface done");
        rq(UIAC_REQ_SET_CONFIG, 8'h02, 8'h00, S, 8'h00);
        rq(UIAC_REQ_SET_CONFIG, 8'h01, 8'h00, A, 8'h00);
        rd(MS, 8'h1c);
        foreach (et[k])
        begin
            wr(E1, et[k][11:4]);
            tk(4'h1, {4'h5, 1'b0, et[k][0], 1'b0, et[k][0]});
        end
        wr(E1, 8'h88);
        wr(E2, 8'h50);
        tk(4'h2, 8'hff);
        for (int k = 0; k < 4; k++)
            rq(UIAC_REQ_EP_FEATURE, 8'h00, 8'(k), (k < 3) ? A : S, 8'h00);
        tk(4'h3, 8'h10);
        rq(UIAC_REQ_SET_CONFIG, 8'h00, 8'h00, A, 8'h00);
        rd(MS, 8'h18);
        tk(4'h1, 8'h10);
        rq(UIAC_REQ_SET_CONFIG, 8'h01, 8'h00, A, 8'h00);
        h.bus_reset();
        rd(MS, 8'h18);
        wr(AL, 8'h04);
        rq(UIAC_REQ_SET_IF, 8'h01, 8'h03, S, 8'h00);
        wr(AL, 8'h1d);
        rq(UIAC_REQ_SET_IF, 8'h04, 8'h00, A, 8'h00);
        $display("test config done");
        wr(DC, 8'hff);
        rd(DC, 8'h40);
        rd(MS, 8'h58);
        rq(UIAC_REQ_GET_DESC_CFG, 8'h02, 8'h00, F, 8'h00);
        wr(DC, 8'h00);
        rq(UIAC_REQ_GET_DESC_CFG, 8'h02, 8'h00, A, 8'h00);
        @(posedge mclk_in);
        desc_hw_set_in <= 1'b1;
        @(posedge mclk_in);
        desc_hw_set_in <= 1'b0;
        rd(DC, 8'h40);
        @(posedge mclk_in);
        desc_hw_set_in <= 1'b1;
        reg_wr_in <= 1'b1;
        reg_addr_in <= DC;
        reg_wdata_in <= 8'h00;
        @(posedge mclk_in);
        desc_hw_set_in <= 1'b0;
        reg_wr_in <= 1'b0;
        rd(DC, 8'h00);
        wr(DC, 8'h40);
        @(posedge mclk_in);
        soft_reset_in <= 1'b1;
        @(posedge mclk_in);
        soft_reset_in <= 1'b0;
        rd(MS, 8'h00);
        repeat (4)
        begin
            r = 8'($urandom);
            wr(E1, r);
            rd(E1, r);
        end
        $display("test routing done");
        repeat (3) @(posedge mclk_in);
        summarize();
    end
endmodule
`default_nettype wire
